//--- rtl/irq_gen_params.svh
`ifndef IRQ_GEN_PARAMS_SVH
`define IRQ_GEN_PARAMS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define OFS_STATUS     8'h00
`define OFS_CLEAR      8'h04
`define OFS_ENABLE     8'h08
`define OFS_ROUTE_OS   8'h0c
`define OFS_CTRL       8'h10
`define OFS_IRQ_STAT   8'h14
`define OFS_IRQ_CLR    8'h18
`define OFS_IRQ_EN     8'h1c
// ==========================================================
// Control register fields
`define CTRL_EOH_BIT   0
`define CTRL_APIC_BIT  1
`define CTRL_SHARE_BIT 2
// ==========================================================
// Reset values
`define RST_ENABLE     8'h00
`define RST_ROUTE_OS   8'h00
`define RST_LINE_SEL   3'h0
// ==========================================================
// Interrupt status bits (block events)
`define IEV_MGMT_SENT  0
`define IEV_OS_RISE    1
// ==========================================================
// Virtual wire message codes
`define VW_MGMT_ASSERT 8'h01
`endif

//--- rtl/irq_gen_pkg.sv
package irq_gen_pkg;
   // ==========================================================
   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // Virtual wire message out
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } vw_msg_t;

   // Legacy or extended interrupt lines driven
   typedef struct packed {
      logic [2:0] legacy;   // 9, 10, 11
      logic [3:0] extended; // 20..23
   } irq_lines_t;

   typedef enum logic [1:0] {
      VW_IDLE,
      VW_SEND,
      VW_WAIT
   } vw_state_t;
endpackage

//--- rtl/os_line_router.sv
`include "irq_gen_params.svh"
// ==========================================================
// Routes the level os_event_interrupt to the selected line
module os_line_router
   import irq_gen_pkg::*;
(
   // Control
   input  wire logic               apic_mode,
   input  wire logic               shared_line,
   input  wire logic [2:0]         line_sel,
   // Level in, lines out
   input  wire logic               level_in,
   output      irq_gen_pkg::irq_lines_t lines
);
   logic lvl;

   // Shared lines run active low, dedicated lines active high
   always_comb begin
      lvl = shared_line ? ~level_in : level_in;
      lines.legacy   = 3'h0;
      lines.extended = 4'h0;
      // Idle value of each line follows the same polarity
      if (shared_line) begin
         lines.legacy   = 3'h7;
         lines.extended = 4'hf;
      end
      case (line_sel)
         3'h0: lines.legacy[0] = lvl;
         3'h1: lines.legacy[1] = lvl;
         3'h2: lines.legacy[2] = lvl;
         3'h3: if (apic_mode) lines.extended[0] = lvl;
         3'h4: if (apic_mode) lines.extended[1] = lvl;
         3'h5: if (apic_mode) lines.extended[2] = lvl;
         3'h6: if (apic_mode) lines.extended[3] = lvl;
         default: lines.legacy[0] = lvl;
      endcase
   end
endmodule // os_line_router

//--- rtl/mgmt_and_os_event_irq_gen.sv
`include "irq_gen_params.svh"
// ==========================================================
module mgmt_and_os_event_irq_gen
   import irq_gen_pkg::*;
#(
   parameter int NSRC = 8
)(
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   // Register port
   input  wire irq_gen_pkg::reg_req_t   req,
   output      logic [31:0]             rdata,
   // Event sources (asynchronous pins)
   input  wire logic [NSRC-1:0]         src_evt,
   // Processor side
   output      irq_gen_pkg::vw_msg_t    vw_out,
   // Interrupt controller side
   output      irq_gen_pkg::irq_lines_t os_lines,
   output      logic                    os_level,
   // Block interrupt
   output      logic                    irq
);
   import irq_gen_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [NSRC-1:0] sync1;
      logic [NSRC-1:0] sync2;
      logic [NSRC-1:0] prev;
      logic [NSRC-1:0] status;
      logic [NSRC-1:0] enable;
      logic [NSRC-1:0] route_os;
      logic            eoh;
      logic            apic;
      logic            share;
      logic [2:0]      line_sel;
      vw_state_t       vw_st;
      vw_msg_t         vw;
      logic            os_lvl;
      irq_lines_t      lines;
      logic [1:0]      ist;
      logic [1:0]      ien;
      logic            irq;
      logic [31:0]     rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   irq_lines_t routed;

   function automatic logic [31:0] zext(input logic [NSRC-1:0] v);
      zext = 32'h0;
      zext[NSRC-1:0] = v;
   endfunction

   logic [NSRC-1:0] rise;
   logic [NSRC-1:0] mgmt_act;
   logic [NSRC-1:0] os_act;
   logic            wr_clr;
   logic            wr_ctrl;
   logic            os_lvl_d;

   // Pending sources that are enabled and steered to each output
   assign rise     = s_r.sync2 & ~s_r.prev;
   assign mgmt_act = s_r.status & s_r.enable & ~s_r.route_os;
   assign os_act   = s_r.status & s_r.enable & s_r.route_os;
   assign wr_clr   = req.wr && (req.addr == `OFS_CLEAR);
   assign wr_ctrl  = req.wr && (req.addr == `OFS_CTRL);
   // Next level kept apart from the state copy, so routing forms no loop through it
   assign os_lvl_d = |os_act;

   // Line routing from the next level, so lines and level flop together
   os_line_router u_router (
      .apic_mode   (s_r.apic),
      .shared_line (s_r.share),
      .line_sel    (s_r.line_sel),
      .level_in    (os_lvl_d),
      .lines       (routed)
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = src_evt;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;
      s_nxt.vw.valid = 1'b0;
      s_nxt.rdata = 32'h0;

      // Sticky status; a new event beats a clear in the same cycle
      if (wr_clr) begin
         s_nxt.status = s_r.status & ~req.wdata[NSRC-1:0];
      end
      s_nxt.status = s_nxt.status | rise;

      // Software register writes
      if (req.wr) begin
         case (req.addr)
            `OFS_ENABLE:   s_nxt.enable   = req.wdata[NSRC-1:0];
            `OFS_ROUTE_OS: s_nxt.route_os = req.wdata[NSRC-1:0];
            `OFS_CTRL: begin
               s_nxt.apic     = req.wdata[`CTRL_APIC_BIT];
               s_nxt.share    = req.wdata[`CTRL_SHARE_BIT];
               s_nxt.line_sel = req.wdata[6:4];
               // Legacy mode keeps the selection within lines 9 to 11
               if (!req.wdata[`CTRL_APIC_BIT] && req.wdata[6:4] > 3'h2) begin
                  s_nxt.line_sel = `RST_LINE_SEL;
               end
            end
            `OFS_IRQ_EN:   s_nxt.ien = req.wdata[1:0];
            default: ;
         endcase
      end

      // Management message sequencer
      case (s_r.vw_st)
         VW_IDLE: begin
            if (s_r.eoh && |mgmt_act) begin
               s_nxt.eoh   = 1'b0;
               s_nxt.vw_st = VW_SEND;
            end
         end
         VW_SEND: begin
            s_nxt.vw.valid = 1'b1;
            s_nxt.vw.code  = `VW_MGMT_ASSERT;
            s_nxt.vw_st    = VW_WAIT;
         end
         VW_WAIT: begin
            // Held off until the handler re-arms the flag
            if (s_r.eoh) begin
               s_nxt.vw_st = VW_IDLE;
            end
         end
         default: s_nxt.vw_st = VW_IDLE;
      endcase
      if (wr_ctrl && req.wdata[`CTRL_EOH_BIT]) begin
         s_nxt.eoh = 1'b1;
      end
      if (s_r.vw_st == VW_WAIT && s_r.eoh && |mgmt_act) begin
         s_nxt.eoh   = 1'b0;
         s_nxt.vw_st = VW_SEND;
      end

      // Level interrupt, no pulse shaping
      s_nxt.os_lvl = os_lvl_d;
      s_nxt.lines  = routed;

      // Block events
      if (req.wr && req.addr == `OFS_IRQ_CLR) begin
         s_nxt.ist = s_r.ist & ~req.wdata[1:0];
      end
      if (s_nxt.vw.valid) begin
         s_nxt.ist[`IEV_MGMT_SENT] = 1'b1;
      end
      if (s_nxt.os_lvl && !s_r.os_lvl) begin
         s_nxt.ist[`IEV_OS_RISE] = 1'b1;
      end
      s_nxt.irq = |(s_nxt.ist & s_nxt.ien);

      // Read data, the cycle after the strobe
      if (req.rd) begin
         case (req.addr)
            `OFS_STATUS:   s_nxt.rdata = zext(s_r.status);
            `OFS_ENABLE:   s_nxt.rdata = zext(s_r.enable);
            `OFS_ROUTE_OS: s_nxt.rdata = zext(s_r.route_os);
            `OFS_CTRL:     s_nxt.rdata = {25'h0, s_r.line_sel, 1'b0, s_r.share, s_r.apic, s_r.eoh};
            `OFS_IRQ_STAT: s_nxt.rdata = {30'h0, s_r.ist};
            `OFS_IRQ_EN:   s_nxt.rdata = {30'h0, s_r.ien};
            default:       s_nxt.rdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_r          <= '0;
         s_r.eoh      <= 1'b1;
         s_r.enable   <= NSRC'(`RST_ENABLE);
         s_r.route_os <= NSRC'(`RST_ROUTE_OS);
         s_r.line_sel <= `RST_LINE_SEL;
         s_r.vw_st    <= VW_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops
   assign rdata    = s_r.rdata;
   assign vw_out   = s_r.vw;
   assign os_lines = s_r.lines;
   assign os_level = s_r.os_lvl;
   assign irq      = s_r.irq;

   // ==========================================================
   // Checks
   // Decision cycle: flag set, enabled management source pending
   sequence fire_s;
      s_r.vw_st == VW_IDLE && s_r.eoh && |mgmt_act;
   endsequence

   // Flag drops first, the message follows one cycle later
   sequence message_s;
      !s_r.eoh ##1 vw_out.valid;
   endsequence

   // Two quiet cycles on the virtual wire
   sequence quiet_s;
      !vw_out.valid [*2];
   endsequence

   // Every decision ends in one message
   mgmt_send_a: assert property (@(posedge clk_sys) disable iff (reset)
      fire_s |=> message_s)
      else $error("management message not sent after event");

   // Only the assert code ever goes out
   vw_code_a: assert property (@(posedge clk_sys) disable iff (reset)
      vw_out.valid |-> vw_out.code == `VW_MGMT_ASSERT)
      else $error("wrong virtual wire code");

   // Messages never come back to back
   one_msg_a: assert property (@(posedge clk_sys) disable iff (reset)
      vw_out.valid |=> quiet_s)
      else $error("back to back management messages");

   // Held off while the handler has not re-armed
   no_resend_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.vw_st == VW_WAIT && !s_r.eoh) |=> quiet_s)
      else $error("message sent before re-arm");

   // Re-armed flag with a pending source resends
   rearm_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.vw_st == VW_WAIT && s_r.eoh && |mgmt_act) |-> ##2 vw_out.valid)
      else $error("re-arm did not resend");

   // Level follows the enabled os sources, one cycle behind
   os_level_a: assert property (@(posedge clk_sys) disable iff (reset)
      |os_act |-> ##1 os_level)
      else $error("os level dropped with active source");

   // No pulse left behind once the sources are gone
   os_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
      !(|os_act) |-> ##1 !os_level)
      else $error("os level held without source");

   // Legacy mode keeps the selection within lines 9 to 11
   legacy_line_a: assert property (@(posedge clk_sys) disable iff (reset)
      !s_r.apic |-> s_r.line_sel <= 3'h2)
      else $error("legacy selection out of range");

   // Extended lines stay idle in legacy mode
   legacy_ext_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!s_r.apic && $stable(s_r.apic) && !s_r.share && $stable(s_r.share)) |-> os_lines.extended == 4'h0)
      else $error("extended line driven in legacy mode");

   // Extended line follows the level when selected
   apic_line_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.apic && !s_r.share && s_r.line_sel == 3'h3 && $stable(s_r.apic) && $stable(s_r.share)
         && $stable(s_r.line_sel)) |-> os_lines.extended[0] == os_level)
      else $error("extended line does not follow level");

   // Dedicated line runs active high
   unshared_line_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!s_r.share && s_r.line_sel == 3'h1 && $stable(s_r.share) && $stable(s_r.line_sel))
         |-> os_lines.legacy[1] == os_level)
      else $error("dedicated line polarity wrong");

   // Status survives until a matching clear
   sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.status[0] && !(wr_clr && req.wdata[0])) |=> s_r.status[0])
      else $error("status bit lost without clear");

   // Disabled sources never reach the level
   gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.enable == '0) |=> !os_level)
      else $error("disabled source reached output");

   // Nothing pending and enabled keeps the sequencer idle
   mgmt_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.vw_st == VW_IDLE && (s_r.status & s_r.enable) == '0) |=> s_r.vw_st == VW_IDLE)
      else $error("message started without enabled source");

   // Sources steered to management never raise the os level
   os_route_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.route_os == '0) |=> !os_level)
      else $error("management source reached os level");

   // Sources steered to the os level never start a message
   mgmt_route_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.vw_st == VW_IDLE && (s_r.enable & ~s_r.route_os) == '0) |=> s_r.vw_st == VW_IDLE)
      else $error("os source started a message");

   // Block event flags mark each message and each level rise
   sent_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
      vw_out.valid |-> s_r.ist[`IEV_MGMT_SENT])
      else $error("message event flag not set");

   os_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(os_level) |-> s_r.ist[`IEV_OS_RISE])
      else $error("level rise event flag not set");

   // Shared line runs active low
   polarity_a: assert property (@(posedge clk_sys) disable iff (reset)
      (s_r.share && !s_r.apic && s_r.line_sel == 3'h0 && $stable(s_r.share) && $stable(s_r.line_sel))
         |-> os_lines.legacy[0] == ~os_level)
      else $error("shared line polarity wrong");
endmodule // mgmt_and_os_event_irq_gen

//--- tb/host_irq_model.sv
`include "irq_gen_params.svh"
// ==========================================================
// Processor and interrupt controller seen from the device
module host_irq_model
   import irq_gen_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   // Device outputs
   input  wire irq_gen_pkg::vw_msg_t    vw_out,
   input  wire irq_gen_pkg::irq_lines_t os_lines,
   // Observations
   output      logic [7:0]              msg_count,
   output      irq_gen_pkg::irq_lines_t os_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // Only whole assert messages count; stray codes are ignored
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         msg_count <= 8'h00;
         os_seen <= 7'h00;
      end else begin
         if (vw_out.valid && vw_out.code == `VW_MGMT_ASSERT) msg_count <= msg_count + 8'h01;
         os_seen <= os_lines;
      end
   end
endmodule // host_irq_model

//--- tb/tb.sv
`include "irq_gen_params.svh"
// ==========================================================
// Top bench
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_gen_pkg::*;
   logic                    clk_sys = 1'b0;
   logic                    reset   = 1'b1;
   reg_req_t                req     = '0;
   logic [7:0]              src_evt = 8'h00;
   logic [31:0]             rdata;
   vw_msg_t                 vw_out;
   irq_lines_t              os_lines;
   irq_lines_t              os_seen;
   logic                    os_level;
   logic                    irq;
   logic [7:0]              msg_count;
   int                      miscompares = 0;
   int                      total_checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   mgmt_and_os_event_irq_gen dut_u (.clk_sys(clk_sys), .reset(reset), .req(req), .rdata(rdata),
      .src_evt(src_evt), .vw_out(vw_out), .os_lines(os_lines), .os_level(os_level), .irq(irq));
   host_irq_model host_u (.clk_sys(clk_sys), .reset(reset), .vw_out(vw_out), .os_lines(os_lines),
      .msg_count(msg_count), .os_seen(os_seen));
   // ==========================================================
   // Bus and compare helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
      // One idle edge so a following call never reassigns the strobe in this step
      @(posedge clk_sys);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 d = rdata;
      total_checks++;
      if (d !== exp) begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, d, exp);
      end
      @(posedge clk_sys);
   endtask
   // Pin pulse long enough to pass the two-flop sync
   task automatic pulse(input int i);
      src_evt[i] <= 1'b1;
      cyc(4);
      src_evt[i] <= 1'b0;
      cyc(1);
   endtask
   // Bounded wait for the host to see a message
   task automatic wait_msg(input logic [7:0] n);
      for (int k = 0; k < 20 && msg_count !== n; k++) cyc(1);
      chk_sig(msg_count, n);
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset();
      chk_reg(`OFS_STATUS, 32'h0);
      chk_reg(`OFS_CTRL, 32'h1);
      chk_reg(8'h20, 32'h0);
      chk_sig({5'h00, os_level, irq, vw_out.valid}, 8'h00);
   endtask
   task automatic test_mgmt();
      wr(`OFS_ENABLE, 32'h3);
      wr(`OFS_IRQ_EN, 32'h1);
      pulse(0);
      wait_msg(8'h01);
      chk_reg(`OFS_CTRL, 32'h0);
      chk_reg(`OFS_STATUS, 32'h1);
      pulse(1);
      cyc(20);
      chk_sig(msg_count, 8'h01);
      wr(`OFS_CTRL, 32'h1);
      wait_msg(8'h02);
      // Interrupt masked, unmasked, then cleared
      chk_sig({7'h00, irq}, 8'h01);
      wr(`OFS_IRQ_EN, 32'h0);
      cyc(2);
      chk_sig({7'h00, irq}, 8'h00);
      wr(`OFS_IRQ_EN, 32'h1);
      cyc(2);
      chk_sig({7'h00, irq}, 8'h01);
      wr(`OFS_IRQ_CLR, 32'h1);
      cyc(2);
      chk_sig({7'h00, irq}, 8'h00);
      wr(`OFS_CLEAR, 32'hff);
      pulse(2);
      wr(`OFS_CTRL, 32'h1);
      cyc(20);
      chk_sig(msg_count, 8'h02);
      chk_reg(`OFS_STATUS, 32'h4);
   endtask
   task automatic test_os();
      wr(`OFS_ENABLE, 32'h18);
      wr(`OFS_ROUTE_OS, 32'h18);
      wr(`OFS_CTRL, 32'h10);
      pulse(3);
      cyc(6);
      chk_sig({7'h00, os_level}, 8'h01);
      chk_sig({1'b0, os_lines}, 8'h20);
      chk_sig({1'b0, os_seen}, 8'h20);
      chk_sig(msg_count, 8'h02);
      pulse(4);
      wr(`OFS_CLEAR, 32'h08);
      cyc(3);
      chk_sig({7'h00, os_level}, 8'h01);
      wr(`OFS_CLEAR, 32'h10);
      cyc(3);
      chk_sig({7'h00, os_level}, 8'h00);
   endtask
   // Every line and both polarities while the level is held
   task automatic test_route();
      logic [7:0] e;
      pulse(3);
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 7; l++) begin
            wr(`OFS_CTRL, 32'((l << 4) | (s << 2) | 2));
            cyc(3);
            e = (l < 3) ? (8'h10 << l) : (8'h01 << (l - 3));
            chk_sig({1'b0, os_lines}, s ? {1'b0, ~e[6:0]} : e);
         end
      end
      wr(`OFS_CTRL, 32'h40);
      cyc(3);
      chk_sig({1'b0, os_lines}, 8'h10);
      wr(`OFS_CLEAR, 32'hff);
      wr(`OFS_CTRL, 32'h4);
      cyc(4);
      chk_sig({1'b0, os_lines}, 8'h7f);
   endtask
   // ==========================================================
   // Verdict and run control
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
   initial begin
      cyc(10);
      reset <= 1'b0;
      @(posedge clk_sys);
      test_reset();
      test_mgmt();
      test_os();
      test_route();
      end_of_test();
   end
endmodule // tb
